// ===== common/pad_ctl_pkg.sv
// Constants for the memory channel pad control register bank
package pad_ctl_pkg;
	localparam int unsigned DW = 32;
	localparam int unsigned AW = 12;
	localparam int unsigned NGRP = 8;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_PD_STR = 10'h0BE;
	localparam logic [9:0] IDX_PU_STR = 10'h0BF;
	localparam logic [9:0] IDX_STEP = 10'h0C0;
	localparam logic [9:0] IDX_SLEW_PD = 10'h0C1;
	localparam logic [9:0] IDX_SLEW_PU = 10'h0C2;
	localparam logic [9:0] IDX_GEN = 10'h0C3;
	localparam logic [9:0] IDX_STATUS = 10'h0D0;
	// Reset values
	localparam logic [31:0] RST_STR = 32'hBBBBBBBB;
	localparam logic [31:0] RST_STEP = 32'h55555555;
	localparam logic [31:0] RST_SLEW = 32'h00000000;
	localparam logic [31:0] RST_GEN = 32'h06006B00;
	localparam logic [31:0] MASK_ALL = 32'hFFFFFFFF;
	localparam logic [31:0] MASK_GEN = 32'h07FFFFFF;
	// General control bit positions
	localparam int unsigned B_FORCE_TRI = 0;
	localparam int unsigned B_DYN_TRI = 1;
	localparam int unsigned B_CLK_TRI = 2;
	localparam int unsigned B_DLL_WAKE = 3;
	localparam int unsigned B_SELFREF = 4;
	localparam int unsigned B_TERM_ON = 5;
	localparam int unsigned B_FORCE_LO = 6;
	localparam int unsigned B_FORCE_HI = 7;
	localparam int unsigned B_DLL_PD = 8;
	localparam int unsigned B_DLL_RST = 9;
	localparam int unsigned B_DLL_TEST = 10;
	localparam int unsigned B_REF_DIS = 11;
	localparam int unsigned B_URG_LO = 12;
	localparam int unsigned B_BIAS_LO = 16;
	localparam int unsigned B_REF_HI = 24;
	localparam int unsigned B_CKE_OE = 25;
	localparam int unsigned B_ODT_OE = 26;
	localparam int unsigned URG_W = 4;
	// Response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Low-power tristate states, Gray except the wake-to-active step
	typedef enum logic [1:0] {
		LP_ACTIVE = 2'h0,
		LP_TRISTATE = 2'h1,
		LP_WAKE = 2'h3
	} lp_state_t;
endpackage

// ===== core/pad_ctl_regs.sv
// Pad control register bank with AXI4-Lite slave and pad steering
`timescale 1ns/10ps

// Function
// - Force bit 0 tristates every channel signal.
// - Bit 1 tristates signals while clock enable low; clock runs, termination low.
// - Bit 2 also tristates memory clock in that low-power state.
// - Bit 3 requests memory DLL reset on leaving clock-tristated state.
// - Bit 4 requests self refresh on entering low-power tristate.
// - Bit 5 keeps data termination always on, else only during reads.
// - Bit 6 forces data and strobe pads low.
// - Bit 7 forces data and strobe pads high.
// - Bits 8-10 DLL power-down, reset, test; reset 1, 1, 0.
// - Bit 11 set, its reset state, blocks all refreshes.
// - Urgent when pending count reaches bits 15:12; bit 24 high priority.
// - Bit 25 drives clock enable output, clear tristates it; resets set.
// - Bit 26 drives termination output, clear tristates it; resets set.
// - Eight 4-bit pull-up preamp strengths, reset 0xB.
// - Two-bit impedance steps per group and polarity, reset 1.
// - Four-bit pull-down and pull-up slew per group, reset 0.
// - Eight bias enables at bits 16-23, cleared at reset.
// - Eight 4-bit pull-down preamp strengths, reset 0xB.
module pad_ctl_regs (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             cke_dyn_low,
	input  wire logic             read_active,
	input  wire logic             refresh_tick,
	input  wire logic [3:0]       refresh_pending,
	output logic                  sig_oe,
	output logic                  mem_clk_oe,
	output logic                  cke_oe,
	output logic                  odt_oe,
	output logic                  odt_force_low,
	output logic                  dq_term_en,
	output logic                  dq_force_low,
	output logic                  dq_force_high,
	output logic                  dll_pd,
	output logic                  dll_rst,
	output logic                  dll_test,
	output logic                  selfref_req,
	output logic                  mem_dll_reset_req,
	output logic                  refresh_issue,
	output logic                  refresh_urgent,
	output logic                  refresh_hi_pri,
	output logic [7:0]            bias_en,
	output logic [31:0]           pd_strength,
	output logic [31:0]           pu_strength,
	output logic [31:0]           imp_step,
	output logic [31:0]           slew_pd,
	output logic [31:0]           slew_pu
);

	// ---------------------------------------------------
	// Helpers
	// ---------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  st,
		input logic [31:0] msk
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r & msk;
	endfunction

	function automatic logic [9:0] word_idx(input logic [11:0] a);
		return a[11:2];
	endfunction

	// ---------------------------------------------------
	// Registers
	// ---------------------------------------------------
	logic [31:0] pd_str_q;
	logic [31:0] pu_str_q;
	logic [31:0] step_q;
	logic [31:0] slew_pd_q;
	logic [31:0] slew_pu_q;
	logic [31:0] gen_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_q;
	logic        w_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic        do_wr;
	logic [9:0]  widx;
	pad_ctl_pkg::lp_state_t lp_q;
	logic        clk_tri_q;

	assign s_axi_awready = ~aw_q & ~bvalid_q;
	assign s_axi_wready = ~w_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign do_wr = aw_q & w_q & ~bvalid_q;
	assign widx = word_idx(awaddr_q);

	// ---------------------------------------------------
	// Write channel
	// ---------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			awaddr_q <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (do_wr) begin
			w_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= pad_ctl_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			case (widx)
				pad_ctl_pkg::IDX_PD_STR,
				pad_ctl_pkg::IDX_PU_STR,
				pad_ctl_pkg::IDX_STEP,
				pad_ctl_pkg::IDX_SLEW_PD,
				pad_ctl_pkg::IDX_SLEW_PU,
				pad_ctl_pkg::IDX_GEN,
				pad_ctl_pkg::IDX_STATUS: begin
					bresp_q <= pad_ctl_pkg::RESP_OKAY;
				end
				default: begin
					bresp_q <= pad_ctl_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_str_q <= pad_ctl_pkg::RST_STR;
			pu_str_q <= pad_ctl_pkg::RST_STR;
			step_q <= pad_ctl_pkg::RST_STEP;
			slew_pd_q <= pad_ctl_pkg::RST_SLEW;
			slew_pu_q <= pad_ctl_pkg::RST_SLEW;
		end else if (do_wr) begin
			case (widx)
				pad_ctl_pkg::IDX_PD_STR: begin
					pd_str_q <= merge(pd_str_q, wdata_q, wstrb_q,
						pad_ctl_pkg::MASK_ALL);
				end
				pad_ctl_pkg::IDX_PU_STR: begin
					pu_str_q <= merge(pu_str_q, wdata_q, wstrb_q,
						pad_ctl_pkg::MASK_ALL);
				end
				pad_ctl_pkg::IDX_STEP: begin
					step_q <= merge(step_q, wdata_q, wstrb_q,
						pad_ctl_pkg::MASK_ALL);
				end
				pad_ctl_pkg::IDX_SLEW_PD: begin
					slew_pd_q <= merge(slew_pd_q, wdata_q, wstrb_q,
						pad_ctl_pkg::MASK_ALL);
				end
				pad_ctl_pkg::IDX_SLEW_PU: begin
					slew_pu_q <= merge(slew_pu_q, wdata_q, wstrb_q,
						pad_ctl_pkg::MASK_ALL);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_q <= pad_ctl_pkg::RST_GEN;
		end else if (do_wr && widx == pad_ctl_pkg::IDX_GEN) begin
			gen_q <= merge(gen_q, wdata_q, wstrb_q,
				pad_ctl_pkg::MASK_GEN);
		end
	end

	// ---------------------------------------------------
	// Read channel
	// ---------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= pad_ctl_pkg::RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= pad_ctl_pkg::RESP_OKAY;
			case (word_idx(s_axi_araddr))
				pad_ctl_pkg::IDX_PD_STR: rdata_q <= pd_str_q;
				pad_ctl_pkg::IDX_PU_STR: rdata_q <= pu_str_q;
				pad_ctl_pkg::IDX_STEP: rdata_q <= step_q;
				pad_ctl_pkg::IDX_SLEW_PD: rdata_q <= slew_pd_q;
				pad_ctl_pkg::IDX_SLEW_PU: rdata_q <= slew_pu_q;
				pad_ctl_pkg::IDX_GEN: rdata_q <= gen_q;
				pad_ctl_pkg::IDX_STATUS: begin
					rdata_q <= {29'h00000000, clk_tri_q, lp_q};
				end
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= pad_ctl_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------
	// Low-power tristate sequencing
	// ---------------------------------------------------
	logic lp_enter;
	logic lp_exit;
	assign lp_enter = lp_q == pad_ctl_pkg::LP_ACTIVE
		&& gen_q[pad_ctl_pkg::B_DYN_TRI] && cke_dyn_low;
	assign lp_exit = lp_q == pad_ctl_pkg::LP_TRISTATE
		&& !(gen_q[pad_ctl_pkg::B_DYN_TRI] && cke_dyn_low);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_q <= pad_ctl_pkg::LP_ACTIVE;
		end else begin
			case (lp_q)
				pad_ctl_pkg::LP_ACTIVE: begin
					if (lp_enter) begin
						lp_q <= pad_ctl_pkg::LP_TRISTATE;
					end
				end
				pad_ctl_pkg::LP_TRISTATE: begin
					if (lp_exit) begin
						lp_q <= pad_ctl_pkg::LP_WAKE;
					end
				end
				pad_ctl_pkg::LP_WAKE: lp_q <= pad_ctl_pkg::LP_ACTIVE;
				default: lp_q <= pad_ctl_pkg::LP_ACTIVE;
			endcase
		end
	end

	// remember clock was tristated this episode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_tri_q <= 1'b0;
		end else if (lp_q == pad_ctl_pkg::LP_TRISTATE) begin
			if (gen_q[pad_ctl_pkg::B_CLK_TRI]) begin
				clk_tri_q <= 1'b1;
			end
		end else if (lp_q == pad_ctl_pkg::LP_ACTIVE) begin
			clk_tri_q <= 1'b0;
		end
	end

	// one-cycle requests on entry and exit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			selfref_req <= 1'b0;
			mem_dll_reset_req <= 1'b0;
		end else begin
			selfref_req <= lp_enter && gen_q[pad_ctl_pkg::B_SELFREF];
			mem_dll_reset_req <= lp_exit
				&& gen_q[pad_ctl_pkg::B_DLL_WAKE]
				&& (clk_tri_q || gen_q[pad_ctl_pkg::B_CLK_TRI]);
		end
	end

	// ---------------------------------------------------
	// Pad steering
	// ---------------------------------------------------
	logic in_lp;
	logic frc;
	assign in_lp = lp_q == pad_ctl_pkg::LP_TRISTATE;
	assign frc = gen_q[pad_ctl_pkg::B_FORCE_TRI];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sig_oe <= 1'b0;
			mem_clk_oe <= 1'b0;
			cke_oe <= 1'b0;
			odt_oe <= 1'b0;
			odt_force_low <= 1'b0;
		end else begin
			sig_oe <= !frc && !in_lp;
			mem_clk_oe <= !frc
				&& !(in_lp && gen_q[pad_ctl_pkg::B_CLK_TRI]);
			cke_oe <= !frc && gen_q[pad_ctl_pkg::B_CKE_OE];
			odt_oe <= !frc && gen_q[pad_ctl_pkg::B_ODT_OE];
			odt_force_low <= in_lp;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dq_term_en <= 1'b0;
			dq_force_low <= 1'b0;
			dq_force_high <= 1'b0;
		end else begin
			dq_term_en <= gen_q[pad_ctl_pkg::B_TERM_ON] || read_active;
			dq_force_low <= gen_q[pad_ctl_pkg::B_FORCE_LO];
			dq_force_high <= gen_q[pad_ctl_pkg::B_FORCE_HI];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_issue <= 1'b0;
			refresh_urgent <= 1'b0;
		end else begin
			refresh_issue <= refresh_tick
				&& !gen_q[pad_ctl_pkg::B_REF_DIS];
			refresh_urgent <= refresh_pending
				>= gen_q[pad_ctl_pkg::B_URG_LO +: pad_ctl_pkg::URG_W];
		end
	end

	assign dll_pd = gen_q[pad_ctl_pkg::B_DLL_PD];
	assign dll_rst = gen_q[pad_ctl_pkg::B_DLL_RST];
	assign dll_test = gen_q[pad_ctl_pkg::B_DLL_TEST];
	assign refresh_hi_pri = gen_q[pad_ctl_pkg::B_REF_HI];
	assign bias_en = gen_q[pad_ctl_pkg::B_BIAS_LO +: pad_ctl_pkg::NGRP];
	assign pd_strength = pd_str_q;
	assign pu_strength = pu_str_q;
	assign imp_step = step_q;
	assign slew_pd = slew_pd_q;
	assign slew_pu = slew_pu_q;

	// ---------------------------------------------------
	// Assertions
	// ---------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence lp_in_s;
		lp_q == pad_ctl_pkg::LP_ACTIVE ##1
		lp_q == pad_ctl_pkg::LP_TRISTATE;
	endsequence

	sequence lp_out_s;
		lp_q == pad_ctl_pkg::LP_TRISTATE ##1
		lp_q == pad_ctl_pkg::LP_WAKE;
	endsequence

	force_tri_a: assert property (
		frc |=> !sig_oe && !mem_clk_oe && !cke_oe && !odt_oe)
		else $error("forced tristate left a pad driven");
	dyn_tri_a: assert property (
		in_lp && !frc |=> !sig_oe && odt_force_low && $past(in_lp))
		else $error("low-power tristate pads wrong");
	clk_tri_a: assert property (
		in_lp && gen_q[pad_ctl_pkg::B_CLK_TRI] |=> !mem_clk_oe)
		else $error("clock not tristated in low power");
	dll_wake_a: assert property (
		lp_out_s ##0 $past(clk_tri_q)
		&& $past(gen_q[pad_ctl_pkg::B_DLL_WAKE])
		|-> mem_dll_reset_req)
		else $error("missing DLL reset on wake");
	selfref_a: assert property (
		lp_in_s ##0 $past(gen_q[pad_ctl_pkg::B_SELFREF])
		|-> selfref_req ##1 !selfref_req)
		else $error("self refresh request wrong");
	term_on_a: assert property (
		gen_q[pad_ctl_pkg::B_TERM_ON] |=> dq_term_en)
		else $error("termination dropped while forced on");
	ref_block_a: assert property (
		gen_q[pad_ctl_pkg::B_REF_DIS] |=> !refresh_issue)
		else $error("refresh issued while disabled");
	urgent_a: assert property (
		refresh_pending
		>= gen_q[pad_ctl_pkg::B_URG_LO +: pad_ctl_pkg::URG_W]
		|=> refresh_urgent)
		else $error("urgency missed at threshold");
	wr_resp_a: assert property (
		do_wr |=> bvalid_q ##0 $stable(widx))
		else $error("write response not one cycle late");
	gen_rsv_a: assert property (
		gen_q[31:27] == 5'h00)
		else $error("reserved bits of general control set");
	rst_val_a: assert property (
		$rose(aresetn) |-> gen_q == pad_ctl_pkg::RST_GEN
		&& pu_str_q == pad_ctl_pkg::RST_STR)
		else $error("reset values wrong");
endmodule

// ===== sim/dram_model.sv
// Memory-side model counting power, DLL and refresh events
`timescale 1ns/10ps
module dram_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       sig_oe,
	input  wire logic       selfref_req,
	input  wire logic       mem_dll_reset_req,
	input  wire logic       refresh_issue,
	output logic      [7:0] sr_cnt,
	output logic      [7:0] dll_cnt,
	output logic      [7:0] ref_cnt,
	output logic            ref_lost
);
	// Event counters seen by the memory
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_cnt <= 8'h00;
			dll_cnt <= 8'h00;
			ref_cnt <= 8'h00;
		end else begin
			sr_cnt <= sr_cnt + {7'h00, selfref_req};
			dll_cnt <= dll_cnt + {7'h00, mem_dll_reset_req};
			ref_cnt <= ref_cnt + {7'h00, refresh_issue};
		end
	end
	// Refresh onto a floating bus never reaches the memory
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ref_lost <= 1'b0;
		else if (refresh_issue && !sig_oe)
			ref_lost <= 1'b1;
	end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the pad control register bank
`timescale 1ns/10ps
module testbench;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0, refresh_pending = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic cke_dyn_low = 0, read_active = 0, refresh_tick = 0;
	logic sig_oe, mem_clk_oe, cke_oe, odt_oe, odt_force_low, dq_term_en;
	logic dq_force_low, dq_force_high, dll_pd, dll_rst, dll_test;
	logic selfref_req, mem_dll_reset_req, refresh_issue, refresh_urgent;
	logic refresh_hi_pri, ref_lost;
	logic [7:0] bias_en, sr_cnt, dll_cnt, ref_cnt;
	logic [31:0] pd_strength, pu_strength, imp_step, slew_pd, slew_pu;
	logic [33:0] exp_q[$];
	logic [31:0] rnd, base;
	logic [31:0] wv[6];
	int n_fail = 0, n_compared = 0;
	logic [7:0] e_sr = 0, e_dll = 0, e_ref = 0;

	pad_ctl_regs u_pad_ctl_regs (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cke_dyn_low, .read_active, .refresh_tick, .refresh_pending,
		.sig_oe, .mem_clk_oe, .cke_oe, .odt_oe, .odt_force_low,
		.dq_term_en, .dq_force_low, .dq_force_high, .dll_pd, .dll_rst,
		.dll_test, .selfref_req, .mem_dll_reset_req, .refresh_issue,
		.refresh_urgent, .refresh_hi_pri, .bias_en, .pd_strength,
		.pu_strength, .imp_step, .slew_pd, .slew_pu);
	dram_model u_dram_model (.aclk, .aresetn, .sig_oe, .selfref_req,
		.mem_dll_reset_req, .refresh_issue, .sr_cnt, .dll_cnt, .ref_cnt,
		.ref_lost);

	always #10 aclk = ~aclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input string nm, input logic [33:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic aw_done, w_done;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_done = 0;
		w_done = 0;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		check("bresp", s_axi_bresp, r);
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [9:0] i, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, d});
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	task gen(input logic [31:0] v);
		wr(pad_ctl_pkg::IDX_GEN, v, 4'hF, pad_ctl_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
	endtask

	// Read answers compared in arrival order
	always @(posedge aclk) begin
		if (aresetn && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			check("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		stop_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h659B));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pad_ctl_pkg::IDX_PU_STR, 32'hBBBBBBBB, 2'h0);
		rd(pad_ctl_pkg::IDX_PD_STR, 32'hBBBBBBBB, 2'h0);
		rd(pad_ctl_pkg::IDX_STEP, 32'h55555555, 2'h0);
		rd(pad_ctl_pkg::IDX_SLEW_PD, 32'h00000000, 2'h0);
		rd(pad_ctl_pkg::IDX_SLEW_PU, 32'h00000000, 2'h0);
		rd(pad_ctl_pkg::IDX_GEN, 32'h06006B00, 2'h0);
		check("dll", {dll_pd, dll_rst, dll_test}, 3'b110);
		check("bias", bias_en, 8'h00);
		check("oe", {cke_oe, odt_oe}, 2'b11);
		$display("test reset values done");
		for (int k = 0; k < 6; k++) begin
			rnd = $urandom();
			wv[k] = rnd;
			wr(10'h0BE + k[9:0], rnd, 4'hF, 2'h0);
			rd(10'h0BE + k[9:0], k == 5 ? rnd & 32'h07FFFFFF : rnd, 2'h0);
		end
		check("pd_strength", pd_strength, wv[0]);
		check("pu_strength", pu_strength, wv[1]);
		check("imp_step", imp_step, wv[2]);
		check("slew_pd", slew_pd, wv[3]);
		check("slew_pu", slew_pu, wv[4]);
		wr(pad_ctl_pkg::IDX_SLEW_PU, 32'hA5A5A5A5, 4'hF, 2'h0);
		wr(pad_ctl_pkg::IDX_SLEW_PU, 32'h3C3C3C3C, 4'h2, 2'h0);
		rd(pad_ctl_pkg::IDX_SLEW_PU, 32'hA5A53CA5, 2'h0);
		wr(10'h0A0, 32'h1, 4'hF, 2'h2);
		rd(10'h0A0, 32'h0, 2'h2);
		$display("test readback done");
		base = 32'h06000000;
		gen(base | 32'h1);
		check("force_tri", {sig_oe, mem_clk_oe, cke_oe}, 3'b000);
		gen(base | 32'h20);
		check("term_on", dq_term_en, 1'b1);
		gen(base);
		check("term_idle", dq_term_en, 1'b0);
		read_active <= 1'b1;
		repeat (3) @(posedge aclk);
		check("term_read", dq_term_en, 1'b1);
		read_active <= 1'b0;
		gen(base | 32'h40);
		check("force_lo", {dq_force_low, dq_force_high}, 2'b10);
		gen(base | 32'h80);
		check("force_hi", {dq_force_low, dq_force_high}, 2'b01);
		gen(32'h0);
		check("oe_off", {cke_oe, odt_oe}, 2'b00);
		gen(base | 32'h800);
		refresh_tick <= 1'b1;
		@(posedge aclk);
		refresh_tick <= 1'b0;
		repeat (3) @(posedge aclk);
		check("ref_blocked", ref_cnt, e_ref);
		rnd = $urandom();
		gen(base | 32'h01005000 | {8'h00, rnd[7:0], 16'h0});
		check("bias_rnd", bias_en, rnd[7:0]);
		check("hi_pri", refresh_hi_pri, 1'b1);
		refresh_tick <= 1'b1;
		refresh_pending <= 4'h4;
		@(posedge aclk);
		refresh_tick <= 1'b0;
		e_ref++;
		repeat (3) @(posedge aclk);
		check("ref_go", ref_cnt, e_ref);
		check("urg_below", refresh_urgent, 1'b0);
		refresh_pending <= 4'h5;
		repeat (3) @(posedge aclk);
		check("urg_at", refresh_urgent, 1'b1);
		$display("test pad controls done");
		for (int k = 0; k < 2; k++) begin
			gen(base | 32'h1A | (k << 2));
			cke_dyn_low <= 1'b1;
			e_sr++;
			repeat (4) @(posedge aclk);
			check("lp_sig", {sig_oe, odt_force_low, cke_oe}, 3'b011);
			check("lp_clk", mem_clk_oe, k == 0);
			check("lp_sr", sr_cnt, e_sr);
			cke_dyn_low <= 1'b0;
			e_dll += k[7:0];
			repeat (5) @(posedge aclk);
			check("wake", {sig_oe, mem_clk_oe, odt_force_low}, 3'b110);
			check("wake_dll", dll_cnt, e_dll);
		end
		check("ref_lost", ref_lost, 1'b0);
		$display("test low power done");
		repeat (4) @(posedge aclk);
		stop_test();
	end
endmodule
